// ### pkg/acmrc_pkg.sv
`default_nettype none
package acmrc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int OSC_START_US = 1000;
  localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam int RATE_MULT = 1024;

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  localparam int DATA_BITS = 24;
  localparam int CMD_BITS = 8;
  localparam logic [7:0] CMD_READ = 8'h5a;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_IRQ_ST = 8'h0c;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h10;
  localparam logic [7:0] ADR_PERIOD = 8'h14;
  localparam logic [7:0] ADR_NOTCH = 8'h18;

  localparam logic [2:0] MODE_CONT = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_IDLE = 3'h2;
  localparam logic [2:0] MODE_PDOWN = 3'h3;

  localparam logic [9:0] RATE_RST = 10'h060;
  localparam logic [2:0] ORDER_RST = 3'h4;
  localparam int IRQ_CONV = 0;
  localparam int IRQ_READ = 1;

  typedef struct packed {
    logic [13:0] rsv;
    logic [9:0] rate;
    logic [2:0] order;
    logic continuous_read_enable;
    logic chop;
    logic [2:0] mode;
  } acmrc_ctrl_s;

  localparam acmrc_ctrl_s CTRL_RST = '{rsv: 14'h0000, rate: RATE_RST, order: ORDER_RST,
                                       continuous_read_enable: 1'b0, chop: 1'b0, mode: MODE_CONT};

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } acmrc_wb_req_s;

  typedef struct packed {
    logic cs_n;
    logic din;
    logic sclk;
  } acmrc_ser_pins_s;

  typedef enum logic [1:0] {CV_PDOWN, CV_OSC, CV_RUN, CV_IDLE} acmrc_conv_e;
  typedef enum logic [1:0] {SR_IDLE, SR_CMD, SR_DATA} acmrc_ser_e;

  typedef struct packed {
    acmrc_conv_e conv;
    acmrc_ser_e ser;
    acmrc_ctrl_s ctrl;
    logic [22:0] cnt;
    logic [19:0] osc;
    logic [2:0] nconv;
    logic settled;
    logic done;
    logic [23:0] data;
    logic rdy_n;
    logic [23:0] sh;
    logic [4:0] bits;
    logic [7:0] cmd;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] lvl;
    logic dout;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    logic filt_rst;
    logic mclk_en;
  } acmrc_state_s;

endpackage
`default_nettype wire

// ### rtl/acmrc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - chop off: one result every 1024 x rate code master clocks.
// - chop on: result period is 1024 x filter order x rate code clocks.
// - chop off, single channel: first notch equals the output rate.
// - chop on: extra notches at odd multiples of half rate; first at order x rate.
// - mode 000 is reset default: convert forever, store each result.
// - conversion done drives status ready bit low, and the data-out/ready pin too unless a serial word is shifting out.
// - continuous read: each result shifts out on serial clocks without commands.
// - after reset or reconfiguration no result until full filter settling.
// - after first settled result, results follow at the programmed rate.
// - mode 001: wake and do exactly one settled conversion.
// - single mode waits up to 1 ms oscillator start before converting.
// - single conversion done: store result, ready low, then power down.
// - data register keeps a result until the next conversion overwrites it.
// - ready stays low until data is read or the control register is written.
// - mode 010: filter and modulator held in reset, modulator clock kept.

module acmrc_core #(
  parameter int OSC_CYC = acmrc_pkg::OSC_START_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire acmrc_pkg::acmrc_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire acmrc_pkg::acmrc_ser_pins_s ser_i,
  output logic dout_rdy_n_o,
  input wire logic [23:0] filt_data_i,
  output logic filt_rst_o,
  output logic mod_clk_en_o,
  output logic conv_done_o,
  output logic irq_o
);
  import acmrc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [22:0] period_f(input acmrc_ctrl_s c);
    logic [12:0] fs;
    logic [12:0] ord;
    // a zero code would stall the divider, so it runs as code one
    fs = {3'h0, (c.rate == 10'h000) ? 10'h001 : c.rate};
    ord = {10'h000, (c.order == 3'h0) ? 3'h1 : c.order};
    if (!c.chop) begin
      ord = 13'h0001;
    end
    period_f = 23'(32'(fs * ord) * RATE_MULT);
  endfunction

  // chop folds the filter order into the period, so one period settles
  function automatic logic [2:0] settle_f(input acmrc_ctrl_s c);
    if (c.chop) begin
      settle_f = 3'h1;
    end else begin
      settle_f = (c.order == 3'h0) ? 3'h1 : c.order;
    end
  endfunction

  function automatic logic [31:0] merge_f(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] s);
    merge_f = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge_f[8*i +: 8] = w[8*i +: 8];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  acmrc_state_s st_r;
  acmrc_state_s n;
  logic bus_wr;
  logic bus_rd;
  logic wr_ctrl;
  logic set_rdy;
  logic clr_rdy;
  logic fall;
  logic rise;
  logic read_done;
  logic [1:0] irq_clr;
  logic [31:0] wmerge;

  assign bus_wr = st_r.ack & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we;
  assign bus_rd = st_r.ack & wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we;
  assign wr_ctrl = bus_wr & (wb_req_i.adr == ADR_CTRL);
  assign wmerge = merge_f(st_r.ctrl, wb_req_i.dat, wb_req_i.sel);

  always_comb begin
    n = st_r;
    set_rdy = 1'b0;
    clr_rdy = 1'b0;
    read_done = 1'b0;
    irq_clr = 2'h0;
    n.done = 1'b0;
    n.filt_rst = 1'b0;
    n.mclk_en = 1'b1;

    // ---------------------------------------------------------------
    // pin synchronisers: a level counts once stages two and three agree
    // ---------------------------------------------------------------
    n.sy1 = {ser_i.cs_n, ser_i.din, ser_i.sclk};
    n.sy2 = st_r.sy1;
    n.sy3 = st_r.sy2;
    n.lvl = (st_r.sy2 & st_r.sy3) | (st_r.lvl & (st_r.sy2 ^ st_r.sy3));
    fall = st_r.lvl[0] & ~n.lvl[0];
    rise = ~st_r.lvl[0] & n.lvl[0];

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    unique case (st_r.conv)
      CV_RUN: begin
        if (st_r.cnt > 23'h00_0001) begin
          n.cnt = st_r.cnt - 23'h00_0001;
        end else begin
          n.cnt = period_f(st_r.ctrl);
          if (st_r.nconv > 3'h1) begin
            n.nconv = st_r.nconv - 3'h1;
          end else begin
            n.done = 1'b1;
            n.data = filt_data_i;
            n.settled = 1'b1;
            set_rdy = 1'b1;
            if (st_r.ctrl.mode == MODE_SINGLE) begin
              n.conv = CV_PDOWN;
              n.ctrl.mode = MODE_PDOWN;
            end
          end
        end
      end
      CV_OSC: begin
        if (st_r.osc > 20'h0_0001) begin
          n.osc = st_r.osc - 20'h0_0001;
        end else begin
          n.conv = CV_RUN;
          n.cnt = period_f(st_r.ctrl);
          n.nconv = settle_f(st_r.ctrl);
        end
      end
      CV_IDLE: begin
        n.filt_rst = 1'b1;
      end
      CV_PDOWN: begin
        n.filt_rst = 1'b1;
        n.mclk_en = 1'b0;
      end
    endcase

    // ---------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, writes at the ack edge
    // ---------------------------------------------------------------
    n.ack = wb_req_i.cyc & wb_req_i.stb & ~st_r.ack;
    if (n.ack) begin
      case (wb_req_i.adr)
        ADR_CTRL: n.rdat = st_r.ctrl;
        ADR_STAT: n.rdat = 32'({st_r.ser, st_r.conv, st_r.settled, st_r.rdy_n});
        ADR_DATA: n.rdat = {8'h00, st_r.data};
        ADR_IRQ_ST: n.rdat = {30'h0000_0000, st_r.irq_st};
        ADR_IRQ_MSK: n.rdat = {30'h0000_0000, st_r.irq_msk};
        ADR_PERIOD: n.rdat = {9'h000, period_f(st_r.ctrl)};
        // first notch sits at order x rate with chop, at rate without; reads 1024 x code either way, not order x 1024 x code with chop
        ADR_NOTCH: n.rdat = 32'(32'(st_r.ctrl.rate) * RATE_MULT);
        default: n.rdat = 32'h0000_0000;
      endcase
    end
    if (bus_rd && wb_req_i.adr == ADR_DATA) begin
      clr_rdy = 1'b1;
    end
    if (bus_wr) begin
      case (wb_req_i.adr)
        ADR_IRQ_ST: irq_clr = wb_req_i.dat[1:0];
        ADR_IRQ_MSK: n.irq_msk = wmerge[1:0];
        default: ;
      endcase
    end
    if (wr_ctrl) begin
      n.ctrl = wmerge;
      n.ctrl.rsv = 14'h0000;
      n.settled = 1'b0;
      clr_rdy = 1'b1;
      case (n.ctrl.mode)
        MODE_CONT: begin
          n.conv = CV_RUN;
          n.cnt = period_f(n.ctrl);
          n.nconv = settle_f(n.ctrl);
        end
        MODE_SINGLE: begin
          n.conv = CV_OSC;
          n.osc = 20'(OSC_CYC);
        end
        MODE_IDLE: n.conv = CV_IDLE;
        default: n.conv = CV_PDOWN;
      endcase
    end

    // ---------------------------------------------------------------
    // serial read-out, clock idles high, data changes on the falling edge
    // ---------------------------------------------------------------
    unique case (st_r.ser)
      SR_IDLE: begin
        if (!n.lvl[2]) begin
          if (st_r.ctrl.continuous_read_enable && !st_r.rdy_n) begin
            n.ser = SR_DATA;
            n.sh = st_r.data;
            n.bits = 5'(DATA_BITS);
          end else if (!st_r.ctrl.continuous_read_enable && rise) begin
            n.ser = SR_CMD;
            n.cmd = {st_r.cmd[6:0], n.lvl[1]};
            n.bits = 5'(CMD_BITS - 1);
          end
        end
      end
      SR_CMD: begin
        if (rise) begin
          n.cmd = {st_r.cmd[6:0], n.lvl[1]};
          n.bits = st_r.bits - 5'h01;
          if (st_r.bits == 5'h01) begin
            // other commands belong to the rest of the port and are dropped here
            n.ser = (n.cmd == CMD_READ) ? SR_DATA : SR_IDLE;
            n.sh = st_r.data;
            n.bits = 5'(DATA_BITS);
          end
        end
      end
      SR_DATA: begin
        if (fall) begin
          n.dout = st_r.sh[23];
          n.sh = {st_r.sh[22:0], 1'b0};
        end
        if (rise) begin
          n.bits = st_r.bits - 5'h01;
          if (st_r.bits == 5'h01) begin
            n.ser = SR_IDLE;
            read_done = 1'b1;
            clr_rdy = 1'b1;
          end
        end
      end
      default: n.ser = SR_IDLE;
    endcase
    // a dropped chip select abandons the word and keeps ready low
    if (n.lvl[2]) begin
      n.ser = SR_IDLE;
    end

    // ---------------------------------------------------------------
    // ready flag and interrupts: a set wins over a clear in the same cycle
    // ---------------------------------------------------------------
    n.rdy_n = set_rdy ? 1'b0 : (clr_rdy ? 1'b1 : st_r.rdy_n);
    n.irq_st[IRQ_CONV] = n.done | (st_r.irq_st[IRQ_CONV] & ~irq_clr[IRQ_CONV]);
    n.irq_st[IRQ_READ] = read_done | (st_r.irq_st[IRQ_READ] & ~irq_clr[IRQ_READ]);
    n.irq = |(n.irq_st & n.irq_msk);
    if (n.ser != SR_DATA) begin
      n.dout = n.rdy_n;
    end

    // taken from the next state so the pins follow a mode change without a cycle of lag
    n.filt_rst = (n.conv == CV_IDLE) || (n.conv == CV_PDOWN);
    n.mclk_en = (n.conv != CV_PDOWN);

    if (rst_i) begin
      n = '0;
      n.ctrl = CTRL_RST;
      n.conv = CV_RUN;
      n.cnt = period_f(CTRL_RST);
      n.nconv = settle_f(CTRL_RST);
      n.rdy_n = 1'b1;
      n.dout = 1'b1;
      n.sy1 = 3'h7;
      n.sy2 = 3'h7;
      n.sy3 = 3'h7;
      n.lvl = 3'h7;
      n.mclk_en = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= n;
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign dout_rdy_n_o = st_r.dout;
  assign filt_rst_o = st_r.filt_rst;
  assign mod_clk_en_o = st_r.mclk_en;
  assign conv_done_o = st_r.done;
  assign irq_o = st_r.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [25:0] since_q;
  logic [22:0] per_w;
  assign per_w = period_f(st_r.ctrl);

  always_ff @(posedge clk_i) begin
    // a restart loads the period at this very edge, so its count begins at zero
    if (rst_i || wr_ctrl || (st_r.conv == CV_OSC && n.conv == CV_RUN)) begin
      since_q <= 26'h000_0000;
    end else if (st_r.done) begin
      since_q <= 26'h000_0001;
    end else begin
      since_q <= since_q + 26'h000_0001;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_single_start;
    wr_ctrl && n.ctrl.mode == MODE_SINGLE;
  endsequence

  sequence s_osc_end;
    st_r.conv == CV_OSC && st_r.osc == 20'h0_0001 && !wr_ctrl;
  endsequence

  AST_RATE_NOCHOP: assert property (st_r.done && $past(st_r.settled) && !st_r.ctrl.chop
    |-> since_q == 26'(32'(st_r.ctrl.rate) * RATE_MULT))
    else $error("result period differs from 1024 x rate code");

  AST_RATE_CHOP: assert property (st_r.done && $past(st_r.settled) && st_r.ctrl.chop
    |-> since_q == 26'(32'(st_r.ctrl.order) * 32'(st_r.ctrl.rate) * RATE_MULT))
    else $error("chopped result period differs from 1024 x order x code");

  AST_SETTLE: assert property (st_r.done && !$past(st_r.settled)
    |-> since_q == 26'(32'(settle_f(st_r.ctrl)) * 32'(per_w)))
    else $error("first result not after full settling time");

  AST_RDY_LOW: assert property (st_r.done && st_r.ser != SR_DATA
    |-> !st_r.rdy_n && !dout_rdy_n_o && st_r.data == $past(filt_data_i))
    else $error("ready not low or data not stored at conversion end");

  AST_SINGLE_PD: assert property (st_r.done && $past(st_r.ctrl.mode) == MODE_SINGLE
    |-> st_r.conv == CV_PDOWN && st_r.ctrl.mode == MODE_PDOWN ##1 filt_rst_o && !mod_clk_en_o)
    else $error("no power-down after single conversion");

  AST_OSC_START: assert property (s_single_start |=> st_r.conv == CV_OSC && st_r.osc == 20'(OSC_CYC))
    else $error("single mode skipped oscillator start wait");

  AST_OSC_END: assert property (s_osc_end |=> st_r.conv == CV_RUN && st_r.nconv == settle_f(st_r.ctrl))
    else $error("single conversion did not start after oscillator wait");

  AST_HOLD: assert property (st_r.data != $past(st_r.data) |-> st_r.done)
    else $error("data register changed without a conversion");

  AST_RDY_HOLD: assert property ($rose(st_r.rdy_n) |-> $past(clr_rdy))
    else $error("ready released without read or reconfiguration");

  AST_IDLE: assert property (st_r.conv == CV_IDLE |-> filt_rst_o && mod_clk_en_o)
    else $error("idle mode must hold filter reset with clocks running");

  AST_CONTINUOUS_READ_ENABLE: assert property (st_r.ser == SR_IDLE && !n.lvl[2] && st_r.ctrl.continuous_read_enable && !st_r.rdy_n
    |=> st_r.ser == SR_DATA && st_r.bits == 5'(DATA_BITS))
    else $error("continuous read did not start on ready");

  AST_PDOWN: assert property (st_r.conv == CV_PDOWN |-> filt_rst_o && !mod_clk_en_o)
    else $error("power-down must hold filter reset with modulator clock off");

  AST_ONE_SHOT: assert property (st_r.conv == CV_PDOWN |=> !st_r.done)
    else $error("result produced while powered down");

endmodule // acmrc_core
`default_nettype wire

// ### verif/acmrc_host.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// host side of the serial port, sclk half period 8 clk = 40 ns
// -------------------------------------------------------------
module acmrc_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output var acmrc_pkg::acmrc_ser_pins_s pins_o
);
  import acmrc_pkg::*;
  localparam int HALF = 8;

  initial pins_o = '{cs_n: 1'b1, din: 1'b1, sclk: 1'b1};

  task automatic half();
    repeat (HALF) @(posedge clk_i);
  endtask

  // din changes while sclk is low; dout is taken at the rising edge
  task automatic pulse(input logic d, output logic q);
    pins_o.sclk <= 1'b0;
    pins_o.din <= d;
    half();
    q = dout_i;
    pins_o.sclk <= 1'b1;
    half();
  endtask

  task automatic read_word(input logic continuous_read_enable, output logic [23:0] w);
    logic q;
    @(posedge clk_i);
    pins_o.cs_n <= 1'b0;
    half();
    if (!continuous_read_enable) begin
      for (int i = 7; i >= 0; i--) begin
        pulse(CMD_READ[i], q);
      end
    end
    // din is not used in the data phase, so it toggles instead of holding
    for (int i = 23; i >= 0; i--) begin
      pulse(~pins_o.din, q);
      w[i] = q;
    end
    pins_o.cs_n <= 1'b1;
    pins_o.din <= ~pins_o.din;
    half();
  endtask
endmodule // acmrc_host
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acmrc_pkg::*;
  localparam int OSC = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  acmrc_wb_req_s wb_req = '0;
  logic [31:0] wb_dat;
  logic wb_ack, dout_rdy_n, filt_rst, mod_clk_en, conv_done, irq;
  logic [23:0] filt_data = 24'h00_0000;
  acmrc_ser_pins_s ser;
  int n_fail = 0;
  int checks = 0;
  int cyc_cnt = 0;

  always #2.5 clk_i = ~clk_i;

  acmrc_core #(.OSC_CYC(OSC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .ser_i(ser), .dout_rdy_n_o(dout_rdy_n), .filt_data_i(filt_data), .filt_rst_o(filt_rst),
    .mod_clk_en_o(mod_clk_en), .conv_done_o(conv_done), .irq_o(irq)
  );
  acmrc_host host_u (.clk_i(clk_i), .dout_i(dout_rdy_n), .pins_o(ser));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // single classic cycle; the global timeout cuts a missing ack short
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  function automatic logic [31:0] ctrl(input logic [9:0] r, input logic [2:0] o, input logic cr,
                                       input logic ch, input logic [2:0] m);
    acmrc_ctrl_s c;
    c = '{rsv: 14'h0000, rate: r, order: o, continuous_read_enable: cr, chop: ch, mode: m};
    return c;
  endfunction

  // edges counted from the call until conv_done_o is seen, 0 if none
  task automatic wait_done(input int lim, output int n);
    n = 0;
    for (int i = 1; i <= lim && n == 0; i++) begin
      @(posedge clk_i);
      #1;
      if (conv_done === 1'b1) n = i;
    end
  endtask

  task automatic single(input logic cr, input logic [23:0] v);
    int n;
    filt_data <= v;
    wr(ADR_CTRL, ctrl(10'h001, 3'h1, cr, 1'b0, MODE_SINGLE));
    wait_done(3000, n);
    chk(n, OSC + RATE_MULT);
    repeat (3) @(posedge clk_i);
    chk1(filt_rst, 1'b1);
    chk1(mod_clk_en, 1'b0);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ADR_CTRL, CTRL_RST);
    rd_chk(ADR_IRQ_MSK, 32'h0000_0000);
    rd_chk(8'h1c, 32'h0000_0000);
    chk1(dout_rdy_n, 1'b1);
  endtask

  task automatic t_cont();
    int n;
    logic [31:0] q;
    filt_data <= 24'ha5_c3_17;
    wr(ADR_CTRL, ctrl(10'h001, 3'h4, 1'b0, 1'b0, MODE_CONT));
    wait_done(6000, n);
    chk(n, 4 * RATE_MULT);
    wait_done(2000, n);
    chk(n, RATE_MULT);
    chk1(dout_rdy_n, 1'b0);
    chk1(filt_rst, 1'b0);
    wb(1'b0, ADR_STAT, 32'h0000_0000, q);
    chk1(q[0], 1'b0);
    rd_chk(ADR_DATA, 32'h00a5_c317);
    rd_chk(ADR_PERIOD, 32'h0000_0400);
    rd_chk(ADR_NOTCH, 32'h0000_0400);
  endtask

  task automatic t_chop();
    int n;
    wr(ADR_CTRL, ctrl(10'h001, 3'h2, 1'b0, 1'b1, MODE_CONT));
    wait_done(5000, n);
    chk(n, 2 * RATE_MULT);
    rd_chk(ADR_PERIOD, 32'h0000_0800);
  endtask

  task automatic t_single();
    int n;
    single(1'b0, 24'h3c_5a_e1);
    wait_done(2500, n);
    chk(n, 0);
    rd_chk(ADR_CTRL, ctrl(10'h001, 3'h1, 1'b0, 1'b0, MODE_PDOWN));
    chk1(dout_rdy_n, 1'b0);
    chk1(irq, 1'b0);
    wr(ADR_IRQ_MSK, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk1(irq, 1'b1);
    wr(ADR_IRQ_ST, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk1(irq, 1'b0);
    rd_chk(ADR_DATA, 32'h003c_5ae1);
    repeat (3) @(posedge clk_i);
    chk1(dout_rdy_n, 1'b1);
  endtask

  task automatic t_serial();
    logic [23:0] w;
    single(1'b0, 24'h96_0f_d2);
    host_u.read_word(1'b0, w);
    chk({8'h00, w}, 32'h0096_0fd2);
    chk1(dout_rdy_n, 1'b1);
    rd_chk(ADR_IRQ_ST, 32'h0000_0003);
    single(1'b1, 24'h4b_e8_79);
    host_u.read_word(1'b1, w);
    chk({8'h00, w}, 32'h004b_e879);
  endtask

  task automatic t_idle();
    int n;
    wr(ADR_CTRL, ctrl(10'h001, 3'h1, 1'b0, 1'b0, MODE_IDLE));
    repeat (3) @(posedge clk_i);
    chk1(filt_rst, 1'b1);
    chk1(mod_clk_en, 1'b1);
    wait_done(2500, n);
    chk(n, 0);
  endtask

  // -------------------------------------------------------------
  // main sequence and timeout
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_cont();
    t_chop();
    t_single();
    t_serial();
    t_idle();
    stop_test();
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      n_fail++;
      stop_test();
    end
  end
endmodule // tb
`default_nettype wire
